//--- inc/phy_mgmt_pkg.sv
package phy_mgmt_pkg;

  // ************************************************************
  // Direct register numbers
  // ************************************************************
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_MMD_CTRL = 5'h0D;
  localparam logic [4:0] REG_MMD_DATA = 5'h0E;
  localparam logic [4:0] REG_STRAP = 5'h1E;

  // ************************************************************
  // Control register fields and fixed values
  // ************************************************************
  localparam int BIT_SW_RESET = 15;
  localparam int BIT_LOOPBACK = 14;
  localparam int BIT_SPEED = 13;
  localparam int BIT_ANEG = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_ISOLATE = 10;
  localparam logic SPEED_FIXED = 1'h1;
  localparam logic ANEG_FIXED = 1'h0;
  localparam logic [9:0] CTRL_RESERVED = 10'h100;

  // ************************************************************
  // Status register fields
  // ************************************************************
  localparam logic [15:0] STATUS_FIXED = 16'h0061;
  localparam int BIT_REMOTE_FAULT = 4;
  localparam int BIT_LINK = 2;
  localparam int BIT_JABBER = 1;

  // ************************************************************
  // Indirect window
  // ************************************************************
  localparam int MMD_FUNC_HI = 15;
  localparam int MMD_FUNC_LO = 14;
  localparam logic [1:0] MMD_FUNC_ADDR = 2'h0;
  localparam logic [4:0] DEVAD_VENDOR = 5'h1F;
  localparam logic [4:0] DEVAD_PMA = 5'h01;
  localparam logic [7:0] VENDOR_PAGE = 8'h02;
  localparam logic [7:0] PMA_PAGE = 8'h00;
  localparam int MEM_WORDS = 16;

  // ************************************************************
  // Timing and reset values
  // ************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int SW_RESET_NS = 1000;
  localparam logic [5:0] SW_RESET_CYCLES = 6'((SW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam logic PIN_IDLE = 1'h1;
  localparam logic [3:0] PHY_ADDR_RESET = 4'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_STRAP = 2'h0,
    ST_RUN = 2'h1,
    ST_SWRST = 2'h3
  } mode_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] phy_addr;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic dv;
    logic [3:0] d;
  } mii_nibble_t;

endpackage

//--- hw/phy_status_latch.sv
`timescale 1ns/1ps
module phy_status_latch #(
  parameter bit LATCH_LOW = 1'h0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cond,
  input wire logic rd_clr,
  output logic latched
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic latched;
  } latch_state_t;

  latch_state_t s_reg;
  latch_state_t s_next;

  // Low type follows the live level once read; high type holds a one until read
  always_comb begin
    s_next = s_reg;
    if (LATCH_LOW) begin
      s_next.latched = rd_clr ? cond : (s_reg.latched & cond);
    end else begin
      s_next.latched = cond | (s_reg.latched & ~rd_clr);
    end
  end

  // Hardware reset clears the latch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign latched = s_reg.latched;

endmodule

//--- hw/phy_mgmt_register_bank.sv
`timescale 1ns/1ps
module phy_mgmt_register_bank (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] strap_phy_addr,
  input wire logic irq_powerdown_pin_n,
  input wire phy_mgmt_pkg::mgmt_req_t mgmt_req,
  output logic mgmt_ack,
  output logic [15:0] mgmt_rdata,
  input wire phy_mgmt_pkg::mii_nibble_t mac_tx,
  output phy_mgmt_pkg::mii_nibble_t mac_rx,
  input wire phy_mgmt_pkg::mii_nibble_t line_rx,
  output phy_mgmt_pkg::mii_nibble_t line_tx,
  input wire logic line_link_ok,
  input wire logic jabber_event,
  input wire logic remote_fault_event,
  output logic link_up,
  output logic power_down
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    phy_mgmt_pkg::mode_t mode;
    logic [1:0] strap_cnt;
    logic [3:0] strap_meta;
    logic [3:0] strap_sync;
    logic [3:0] phy_addr;
    logic pin_meta;
    logic pin_sync;
    logic loopback;
    logic power_down;
    logic isolate;
    logic [5:0] rst_cnt;
    logic [15:0] mmd_ctrl;
    logic [15:0] mmd_addr;
    logic [15:0][15:0] vendor_mem;
    logic [15:0][15:0] pma_mem;
    logic ack;
    logic [15:0] rdata;
    phy_mgmt_pkg::mii_nibble_t mac_rx;
    phy_mgmt_pkg::mii_nibble_t line_tx;
    logic link_up;
    logic pd_out;
  } state_t;

  // Busy window plus margin, so the self-clear check tracks the package count
  localparam int SWRST_WAIT = phy_mgmt_pkg::SW_RESET_CYCLES + 10;

  state_t s_reg;
  state_t s_next;
  logic req_hit;
  logic data_via_window;
  logic win_vendor;
  logic win_pma;
  logic status_rd;
  logic pd_eff;
  logic link_cond;
  logic link_held;
  logic jabber_held;
  logic fault_held;
  logic [15:0] status_word;
  logic [15:0] rd_value;

  // ************************************************************
  // Register helpers
  // ************************************************************
  // Control word view; busy flag reads one for the whole soft reset
  function automatic logic [15:0] ctrl_word(input state_t s);
    logic [15:0] w;
    w = '0;
    w[phy_mgmt_pkg::BIT_SW_RESET] = (s.mode == phy_mgmt_pkg::ST_SWRST);
    w[phy_mgmt_pkg::BIT_LOOPBACK] = s.loopback;
    w[phy_mgmt_pkg::BIT_SPEED] = phy_mgmt_pkg::SPEED_FIXED;
    w[phy_mgmt_pkg::BIT_ANEG] = phy_mgmt_pkg::ANEG_FIXED;
    w[phy_mgmt_pkg::BIT_POWER_DOWN] = s.power_down;
    w[phy_mgmt_pkg::BIT_ISOLATE] = s.isolate;
    w[9:0] = phy_mgmt_pkg::CTRL_RESERVED;
    return w;
  endfunction

  // Shared by direct and windowed reads; window registers are not mapped into themselves
  function automatic logic [15:0] read_word(input state_t s, input logic vendor, input logic pma,
                                            input logic [11:0] a, input logic [15:0] status);
    logic [15:0] w;
    w = '0;
    if (vendor && a == {7'h00, phy_mgmt_pkg::REG_CONTROL}) begin
      w = ctrl_word(s);
    end else if (vendor && a == {7'h00, phy_mgmt_pkg::REG_STATUS}) begin
      w = status;
    end else if (vendor && a == {7'h00, phy_mgmt_pkg::REG_STRAP}) begin
      w = {12'h000, s.phy_addr};
    end else if (vendor && a[11:4] == phy_mgmt_pkg::VENDOR_PAGE) begin
      w = s.vendor_mem[a[3:0]];
    end else if (pma && a[11:4] == phy_mgmt_pkg::PMA_PAGE) begin
      w = s.pma_mem[a[3:0]];
    end
    return w;
  endfunction

  // Read-only and reserved control bits are dropped on write
  function automatic state_t write_word(input state_t s, input logic vendor, input logic pma,
                                        input logic [11:0] a, input logic [15:0] d);
    state_t r;
    r = s;
    if (vendor && a == {7'h00, phy_mgmt_pkg::REG_CONTROL}) begin
      r.loopback = d[phy_mgmt_pkg::BIT_LOOPBACK];
      r.power_down = d[phy_mgmt_pkg::BIT_POWER_DOWN];
      r.isolate = d[phy_mgmt_pkg::BIT_ISOLATE];
      if (d[phy_mgmt_pkg::BIT_SW_RESET]) begin
        r.mode = phy_mgmt_pkg::ST_SWRST;
        r.rst_cnt = phy_mgmt_pkg::SW_RESET_CYCLES - 6'h01;
      end
    end else if (vendor && a[11:4] == phy_mgmt_pkg::VENDOR_PAGE) begin
      r.vendor_mem[a[3:0]] = d;
    end else if (pma && a[11:4] == phy_mgmt_pkg::PMA_PAGE) begin
      r.pma_mem[a[3:0]] = d;
    end
    return r;
  endfunction

  // ************************************************************
  // Request decode
  // ************************************************************
  // Requests are ignored until the strapped address is known; only four address bits are strapped, the fifth must be zero
  assign req_hit = mgmt_req.valid && (s_reg.mode != phy_mgmt_pkg::ST_STRAP) &&
                   (mgmt_req.phy_addr == {1'h0, s_reg.phy_addr});
  assign data_via_window = (mgmt_req.reg_addr == phy_mgmt_pkg::REG_MMD_DATA) &&
                           (s_reg.mmd_ctrl[phy_mgmt_pkg::MMD_FUNC_HI:phy_mgmt_pkg::MMD_FUNC_LO] !=
                            phy_mgmt_pkg::MMD_FUNC_ADDR);
  assign win_vendor = (s_reg.mmd_ctrl[4:0] == phy_mgmt_pkg::DEVAD_VENDOR);
  assign win_pma = (s_reg.mmd_ctrl[4:0] == phy_mgmt_pkg::DEVAD_PMA);
  assign status_rd = req_hit && !mgmt_req.write &&
                     ((mgmt_req.reg_addr == phy_mgmt_pkg::REG_STATUS) ||
                      (data_via_window && win_vendor &&
                       s_reg.mmd_addr[11:0] == {7'h00, phy_mgmt_pkg::REG_STATUS}));

  // Effective power-down; the pin is used only after two flops
  assign pd_eff = s_reg.power_down | ~s_reg.pin_sync;
  assign link_cond = s_reg.link_up;

  // ************************************************************
  // Status latches
  // ************************************************************
  phy_status_latch #(.LATCH_LOW(1'h1)) u_link_latch (.clk(clk), .nrst(nrst), .cond(link_cond),
    .rd_clr(status_rd), .latched(link_held));
  phy_status_latch #(.LATCH_LOW(1'h0)) u_jabber_latch (.clk(clk), .nrst(nrst), .cond(jabber_event),
    .rd_clr(status_rd), .latched(jabber_held));
  phy_status_latch #(.LATCH_LOW(1'h0)) u_fault_latch (.clk(clk), .nrst(nrst), .cond(remote_fault_event),
    .rd_clr(status_rd), .latched(fault_held));

  // Status word from fixed bits and latched bits
  always_comb begin
    status_word = phy_mgmt_pkg::STATUS_FIXED;
    status_word[phy_mgmt_pkg::BIT_REMOTE_FAULT] = fault_held;
    status_word[phy_mgmt_pkg::BIT_LINK] = link_held;
    status_word[phy_mgmt_pkg::BIT_JABBER] = jabber_held;
  end

  // Read mux; the data register shows the held address in address function
  always_comb begin
    rd_value = '0;
    if (mgmt_req.reg_addr == phy_mgmt_pkg::REG_MMD_CTRL) begin
      rd_value = s_reg.mmd_ctrl;
    end else if (mgmt_req.reg_addr == phy_mgmt_pkg::REG_MMD_DATA) begin
      rd_value = data_via_window ?
                 read_word(s_reg, win_vendor, win_pma, s_reg.mmd_addr[11:0], status_word) :
                 s_reg.mmd_addr;
    end else begin
      rd_value = read_word(s_reg, 1'h1, 1'h0, {7'h00, mgmt_req.reg_addr}, status_word);
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'h0;
    s_next.pin_meta = irq_powerdown_pin_n;
    s_next.pin_sync = s_reg.pin_meta;
    s_next.strap_meta = strap_phy_addr;
    s_next.strap_sync = s_reg.strap_meta;
    unique case (s_reg.mode)
      phy_mgmt_pkg::ST_STRAP: begin
        // Wait for the synchroniser to fill before catching the straps
        if (s_reg.strap_cnt == phy_mgmt_pkg::STRAP_SETTLE) begin
          s_next.phy_addr = s_reg.strap_sync;
          s_next.mode = phy_mgmt_pkg::ST_RUN;
        end else begin
          s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
        end
      end
      phy_mgmt_pkg::ST_RUN: begin
      end
      phy_mgmt_pkg::ST_SWRST: begin
        // Coding registers clear at the end; vendor words are left alone
        if (s_reg.rst_cnt == 6'h00) begin
          s_next.mode = phy_mgmt_pkg::ST_RUN;
          s_next.loopback = 1'h0;
          s_next.power_down = 1'h0;
          s_next.isolate = 1'h0;
          s_next.pma_mem = '0;
        end else begin
          s_next.rst_cnt = s_reg.rst_cnt - 6'h01;
        end
      end
      default: begin
        s_next.mode = phy_mgmt_pkg::ST_RUN;
      end
    endcase
    if (req_hit) begin
      s_next.ack = 1'h1;
      s_next.rdata = rd_value;
      if (mgmt_req.write) begin
        if (mgmt_req.reg_addr == phy_mgmt_pkg::REG_MMD_CTRL) begin
          s_next.mmd_ctrl = mgmt_req.wdata;
        end else if (mgmt_req.reg_addr == phy_mgmt_pkg::REG_MMD_DATA && !data_via_window) begin
          s_next.mmd_addr = mgmt_req.wdata;
        end else if (data_via_window) begin
          // Held address is not advanced in any data function
          s_next = write_word(s_next, win_vendor, win_pma, s_reg.mmd_addr[11:0], mgmt_req.wdata);
        end else begin
          s_next = write_word(s_next, 1'h1, 1'h0, {7'h00, mgmt_req.reg_addr}, mgmt_req.wdata);
        end
      end
    end
    // Pin wins over a software clear in the same cycle
    if (!s_reg.pin_sync) begin
      s_next.power_down = 1'h1;
    end
    // Data paths; isolate and power-down leave the MAC side quiet
    s_next.pd_out = pd_eff;
    if (pd_eff || s_reg.isolate) begin
      s_next.mac_rx = '0;
    end else if (s_reg.loopback) begin
      s_next.mac_rx = mac_tx;
    end else begin
      s_next.mac_rx = line_rx;
    end
    s_next.line_tx = (pd_eff || s_reg.isolate || s_reg.loopback) ? '0 : mac_tx;
    s_next.link_up = line_link_ok && !s_reg.loopback && !pd_eff &&
                     (s_reg.mode == phy_mgmt_pkg::ST_RUN);
  end

  // Constants only under reset; the pin flops idle high so no false power-down
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.phy_addr <= phy_mgmt_pkg::PHY_ADDR_RESET;
      s_reg.pin_meta <= phy_mgmt_pkg::PIN_IDLE;
      s_reg.pin_sync <= phy_mgmt_pkg::PIN_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign mgmt_ack = s_reg.ack;
  assign mgmt_rdata = s_reg.rdata;
  assign mac_rx = s_reg.mac_rx;
  assign line_tx = s_reg.line_tx;
  assign link_up = s_reg.link_up;
  assign power_down = s_reg.pd_out;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence swrst_write;
    req_hit && mgmt_req.write && mgmt_req.reg_addr == phy_mgmt_pkg::REG_CONTROL && mgmt_req.wdata[15];
  endsequence

  sequence swrst_busy;
    (s_reg.mode == phy_mgmt_pkg::ST_SWRST)[*8];
  endsequence

  AST_STRAP_LOAD: assert property (
    (s_reg.mode == phy_mgmt_pkg::ST_STRAP && s_reg.strap_cnt == phy_mgmt_pkg::STRAP_SETTLE)
    |=> (s_reg.phy_addr == $past(s_reg.strap_sync)) && s_reg.mode == phy_mgmt_pkg::ST_RUN)
    else $error("strap address not loaded");
  AST_HIGH_HOLD: assert property ((jabber_held && !status_rd) |=> jabber_held)
    else $error("latched-high bit lost before read");
  AST_LOW_DROP: assert property (!link_cond |=> !link_held)
    else $error("latched-low bit missed a drop");
  AST_SWRST_SELF_CLEAR: assert property (
    swrst_write |=> swrst_busy ##[1:SWRST_WAIT] (s_reg.mode == phy_mgmt_pkg::ST_RUN))
    else $error("soft reset did not run and clear");
  AST_DIRECT_ACK: assert property (req_hit |=> mgmt_ack)
    else $error("direct access not answered");
  AST_VENDOR_KEEP: assert property (
    (s_reg.mode == phy_mgmt_pkg::ST_SWRST && s_reg.rst_cnt == 6'h00 && !req_hit)
    |=> s_reg.vendor_mem == $past(s_reg.vendor_mem) && s_reg.pma_mem == '0)
    else $error("soft reset touched vendor words");
  AST_BUSY_READ: assert property (
    (req_hit && !mgmt_req.write && mgmt_req.reg_addr == phy_mgmt_pkg::REG_CONTROL)
    |=> mgmt_rdata[15] == ($past(s_reg.mode) == phy_mgmt_pkg::ST_SWRST)
        && mgmt_rdata[13:12] == 2'h2 && mgmt_rdata[9:0] == phy_mgmt_pkg::CTRL_RESERVED)
    else $error("control word read back wrong");
  AST_LOOPBACK: assert property (
    (s_reg.loopback && !pd_eff && !s_reg.isolate) |=> mac_rx == $past(mac_tx))
    else $error("loopback data not returned");
  AST_NO_LINK_LOOP: assert property (s_reg.loopback |=> !link_up)
    else $error("link shown during loopback");
  AST_PD_OR: assert property (##1 power_down == $past(s_reg.power_down | ~s_reg.pin_sync))
    else $error("power-down output not the OR");
  AST_PIN_SETS_PD: assert property (!s_reg.pin_sync |=> s_reg.power_down)
    else $error("pin did not set power-down bit");
  AST_ISOLATE: assert property (s_reg.isolate |=> mac_rx == '0 && line_tx == '0)
    else $error("isolate left MAC side driven");
  AST_NO_INC: assert property ((req_hit && data_via_window) |=> s_reg.mmd_addr == $past(s_reg.mmd_addr))
    else $error("window address moved");

endmodule

//--- tb/mgmt_ctrl_model.sv
`timescale 1ns/1ps
// ****************************************
// Station management controller model
// ****************************************
module mgmt_ctrl_model (
  input wire logic clk,
  input wire logic mgmt_ack,
  input wire logic [15:0] mgmt_rdata,
  output phy_mgmt_pkg::mgmt_req_t mgmt_req
);
  initial mgmt_req = '0;

  // One pulse per request, then wait a bounded time for the answer
  // Fields are scrambled once released so stale values cannot pass
  task automatic xfer(input logic w, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ok);
    int i;
    @(negedge clk);
    mgmt_req = '{1'b1, w, pa, ra, wd};
    @(negedge clk);
    mgmt_req = '{1'b0, ~w, ~pa, ~ra, ~wd};
    ok = 1'b0;
    rd = 16'h0000;
    for (i = 0; i < 3 && !ok; i++) begin
      if (mgmt_ack === 1'b1) begin
        ok = 1'b1;
        rd = mgmt_rdata;
      end else begin
        @(negedge clk);
      end
    end
  endtask

  // Window set-up: code, address, then data function with the code
  task automatic window(input logic [4:0] pa, input logic [4:0] dev, input logic [15:0] addr);
    logic [15:0] rd;
    logic ok;
    xfer(1'b1, pa, phy_mgmt_pkg::REG_MMD_CTRL, {11'h000, dev}, rd, ok);
    xfer(1'b1, pa, phy_mgmt_pkg::REG_MMD_DATA, addr, rd, ok);
    xfer(1'b1, pa, phy_mgmt_pkg::REG_MMD_CTRL, 16'h4000 | {11'h000, dev}, rd, ok);
  endtask
endmodule

//--- tb/phy_mgmt_register_bank_bench.sv
`timescale 1ns/1ps
module phy_mgmt_register_bank_bench;
  logic clk;
  logic nrst;
  logic [3:0] strap_phy_addr;
  logic irq_powerdown_pin_n;
  phy_mgmt_pkg::mgmt_req_t mgmt_req;
  logic mgmt_ack;
  logic [15:0] mgmt_rdata;
  phy_mgmt_pkg::mii_nibble_t mac_tx;
  phy_mgmt_pkg::mii_nibble_t mac_rx;
  phy_mgmt_pkg::mii_nibble_t line_rx;
  phy_mgmt_pkg::mii_nibble_t line_tx;
  logic line_link_ok;
  logic jabber_event;
  logic remote_fault_event;
  logic link_up;
  logic power_down;
  int mismatches;
  int n_tests;
  int cycles;
  logic [15:0] got;
  logic ok;
  localparam logic [4:0] PA = 5'h05;

  phy_mgmt_register_bank dut_u (.clk(clk), .nrst(nrst), .strap_phy_addr(strap_phy_addr),
    .irq_powerdown_pin_n(irq_powerdown_pin_n), .mgmt_req(mgmt_req), .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata),
    .mac_tx(mac_tx), .mac_rx(mac_rx), .line_rx(line_rx), .line_tx(line_tx), .line_link_ok(line_link_ok),
    .jabber_event(jabber_event), .remote_fault_event(remote_fault_event), .link_up(link_up),
    .power_down(power_down));
  mgmt_ctrl_model model_u (.clk(clk), .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata), .mgmt_req(mgmt_req));

  // ****************************************
  // Clock and hang guard
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Whole run is a few hundred cycles, so the ceiling is generous
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      mismatches++;
      stop_test();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string msg);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, g, e);
    end
  endtask

  task automatic rd(input logic [4:0] ra, input logic [15:0] e, input logic [15:0] m);
    model_u.xfer(1'b0, PA, ra, 16'h0000, got, ok);
    chk({15'h0000, ok}, 16'h0001, "read ack");
    chk(got & m, e, "read data");
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    model_u.xfer(1'b1, PA, ra, wd, got, ok);
    chk({15'h0000, ok}, 16'h0001, "write ack");
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    nrst = 1'b0;
    strap_phy_addr = 4'h5;
    irq_powerdown_pin_n = 1'b1;
    mac_tx = '0;
    line_rx = '0;
    line_link_ok = 1'b0;
    jabber_event = 1'b0;
    remote_fault_event = 1'b0;
    cyc(3);
    nrst = 1'b1;
    cyc(4);
    // Reset value, strapped address, foreign address refused
    rd(phy_mgmt_pkg::REG_CONTROL, 16'h2100, 16'hffff);
    rd(phy_mgmt_pkg::REG_STRAP, 16'h0005, 16'hffff);
    model_u.xfer(1'b0, 5'h00, phy_mgmt_pkg::REG_CONTROL, 16'h0000, got, ok);
    chk({15'h0000, ok}, 16'h0000, "foreign address");
    rd(5'h10, 16'h0000, 16'hffff);
    $display("test reset done");
    // Read-only and reserved bits ignored on write
    wr(phy_mgmt_pkg::REG_CONTROL, 16'h7fff);
    rd(phy_mgmt_pkg::REG_CONTROL, 16'h6d00, 16'hffff);
    chk({15'h0000, power_down}, 16'h0001, "pd bit");
    // Loopback: transmit returns, no link even with the line up
    wr(phy_mgmt_pkg::REG_CONTROL, 16'h4000);
    line_link_ok = 1'b1;
    mac_tx = 5'h1b;
    cyc(3);
    chk({11'h000, mac_rx}, 16'h001b, "loopback");
    chk({15'h0000, link_up}, 16'h0000, "link in loopback");
    wr(phy_mgmt_pkg::REG_CONTROL, 16'h0000);
    line_rx = 5'h16;
    cyc(3);
    chk({15'h0000, link_up}, 16'h0001, "link normal");
    chk({11'h000, mac_rx}, 16'h0016, "rx path");
    chk({11'h000, line_tx}, 16'h001b, "tx path");
    wr(phy_mgmt_pkg::REG_CONTROL, 16'h0400);
    cyc(3);
    chk({11'h000, mac_rx}, 16'h0000, "isolate rx");
    chk({11'h000, line_tx}, 16'h0000, "isolate tx");
    rd(phy_mgmt_pkg::REG_STRAP, 16'h0005, 16'hffff);
    wr(phy_mgmt_pkg::REG_CONTROL, 16'h0000);
    $display("test control done");
    // Pin power-down sets the bit and the output
    irq_powerdown_pin_n = 1'b0;
    cyc(5);
    chk({15'h0000, power_down}, 16'h0001, "pin pd");
    rd(phy_mgmt_pkg::REG_CONTROL, 16'h0800, 16'h0800);
    irq_powerdown_pin_n = 1'b1;
    cyc(5);
    wr(phy_mgmt_pkg::REG_CONTROL, 16'h0000);
    cyc(3);
    chk({15'h0000, power_down}, 16'h0000, "pd off");
    $display("test powerdown done");
    // Latched status bits
    rd(phy_mgmt_pkg::REG_STATUS, 16'h0000, 16'h0000);
    rd(phy_mgmt_pkg::REG_STATUS, 16'h0065, 16'hffff);
    jabber_event = 1'b1;
    cyc(1);
    jabber_event = 1'b0;
    remote_fault_event = 1'b1;
    cyc(1);
    remote_fault_event = 1'b0;
    cyc(2);
    rd(phy_mgmt_pkg::REG_STATUS, 16'h0077, 16'hffff);
    rd(phy_mgmt_pkg::REG_STATUS, 16'h0065, 16'hffff);
    line_link_ok = 1'b0;
    cyc(1);
    line_link_ok = 1'b1;
    cyc(3);
    rd(phy_mgmt_pkg::REG_STATUS, 16'h0061, 16'hffff);
    rd(phy_mgmt_pkg::REG_STATUS, 16'h0065, 16'hffff);
    $display("test status done");
    // Indirect window, both spaces, address held
    model_u.window(PA, phy_mgmt_pkg::DEVAD_VENDOR, 16'h0020);
    wr(phy_mgmt_pkg::REG_MMD_DATA, 16'ha5a5);
    rd(phy_mgmt_pkg::REG_MMD_DATA, 16'ha5a5, 16'hffff);
    rd(phy_mgmt_pkg::REG_MMD_DATA, 16'ha5a5, 16'hffff);
    model_u.window(PA, phy_mgmt_pkg::DEVAD_VENDOR, 16'h0000);
    rd(phy_mgmt_pkg::REG_MMD_DATA, 16'h2100, 16'hffff);
    model_u.window(PA, phy_mgmt_pkg::DEVAD_PMA, 16'h0003);
    wr(phy_mgmt_pkg::REG_MMD_DATA, 16'h1234);
    rd(phy_mgmt_pkg::REG_MMD_DATA, 16'h1234, 16'hffff);
    $display("test window done");
    // Soft reset: busy, self-clears, vendor words survive
    wr(phy_mgmt_pkg::REG_CONTROL, 16'hc000);
    rd(phy_mgmt_pkg::REG_CONTROL, 16'h8000, 16'h8000);
    cyc(60);
    rd(phy_mgmt_pkg::REG_CONTROL, 16'h2100, 16'hffff);
    rd(phy_mgmt_pkg::REG_MMD_DATA, 16'h0000, 16'hffff);
    model_u.window(PA, phy_mgmt_pkg::DEVAD_VENDOR, 16'h0020);
    rd(phy_mgmt_pkg::REG_MMD_DATA, 16'ha5a5, 16'hffff);
    $display("test softreset done");
    // Hard reset again with new straps: address reloads, held status bits clear
    jabber_event = 1'b1;
    cyc(1);
    jabber_event = 1'b0;
    nrst = 1'b0;
    strap_phy_addr = 4'ha;
    cyc(3);
    nrst = 1'b1;
    cyc(4);
    model_u.xfer(1'b0, 5'h0a, phy_mgmt_pkg::REG_STRAP, 16'h0000, got, ok);
    chk(got, 16'h000a, "strap reload");
    model_u.xfer(1'b0, 5'h0a, phy_mgmt_pkg::REG_STATUS, 16'h0000, got, ok);
    chk(got, 16'h0061, "status after reset");
    $display("test rereset done");
    stop_test();
  end
endmodule
